// [shc_map.svh]
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH

// ============================================================
// address byte fields
`define SHC_ADDR_MATCH_HI   7
`define SHC_ADDR_MATCH_LO   2
`define SHC_ADDR_PATH_BIT   1
`define SHC_ADDR_RW_BIT     0

// ============================================================
// command ordinals
`define SHC_ORD_FIRMWARE_VERIFY     8'h01
`define SHC_ORD_STARTUP_INIT        8'h02
`define SHC_ORD_CHALLENGE_REPLY     8'h03
`define SHC_ORD_AUTH_STEP_ONE       8'h04
`define SHC_ORD_AUTH_STEP_TWO       8'h05
`define SHC_ORD_PASSWORD_ENCRYPT    8'h06
`define SHC_ORD_ENCRYPT_STEP_ONE    8'h07
`define SHC_ORD_ENCRYPT_STEP_TWO    8'h08
`define SHC_ORD_BYTE_GRIND          8'h09
`define SHC_ORD_RANDOM_FETCH        8'h0A
`define SHC_ORD_COUNTER_INCREMENT   8'h0B
`define SHC_ORD_COUNTER_READ        8'h0C
`define SHC_ORD_MEMORY_WRITE        8'h0D
`define SHC_ORD_MEMORY_WRITE_ENC    8'h0E
`define SHC_ORD_MEMORY_WRITE_AUTH   8'h0F
`define SHC_ORD_MEMORY_READ         8'h10
`define SHC_ORD_MEMORY_READ_DIGEST  8'h11
`define SHC_ORD_MAKER_ID_READ       8'h12
`define SHC_ORD_LOCK_MEMORY         8'h13
`define SHC_ORD_CLEAR_STATE         8'h14
`define SHC_ORD_CRUNCH_OP           8'h15

// ============================================================
// status reset value and timing
`define SHC_STATUS_RESET    8'h00
`define SHC_CLK_NS          10
`define SHC_EXEC_MAX_NS     20000000
`define SHC_EXEC_MAX_CYC    (`SHC_EXEC_MAX_NS / `SHC_CLK_NS)
`define SHC_SEC_DELAY_CYC   1000

`endif

// [shc_pkg.sv]
package shc_pkg;

  // ============================================================
  // link state machine, gray along address, ack and data path
  typedef enum logic [2:0] {
    SHC_IDLE = 3'h0,
    SHC_ADDR = 3'h1,
    SHC_AACK = 3'h3,
    SHC_WRB  = 3'h2,
    SHC_WACK = 3'h6,
    SHC_RDB  = 3'h7,
    SHC_RACK = 3'h5
  } shc_state_e;

  typedef enum logic [2:0] {
    SHC_ERR_OK        = 3'h0,
    SHC_ERR_RST_LOCK  = 3'h1,
    SHC_ERR_BAD_CMD   = 3'h2,
    SHC_ERR_TIMED     = 3'h3,
    SHC_ERR_AUTH      = 3'h4
  } shc_err_e;

  typedef struct packed {
    shc_err_e   err;
    logic [1:0] rsvd;
    logic       init_complete;
    logic       busy;
    logic       output_ready;
  } shc_stat_s;

endpackage : shc_pkg

// [shc_buf_mem.sv]
`timescale 1ns/1ns

module shc_buf_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [DW-1:0] rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [DW-1:0] rdata_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ============================================================
  // one write port shared by time, two registered read ports
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule : shc_buf_mem

// [shc_cmd_port.sv]
`timescale 1ns/1ns
`include "shc_map.svh"
// Operation
// - first written byte is command ordinal
// - second byte counts operands, then operands follow
// - legal ordinal is acked and execution starts
// - execution lasts at most 20 ms
// - ordinal 0x15 or above locks for delay
// - ordinals 0x01 to 0x0A decode as listed
// - ordinals 0x0B to 0x14 decode as listed
// - response read returns size then data bytes
// - response rereadable until a new command
// - old output ready kept while operands arrive
// - no-output completion clears ready, size zero
// - status read returns one status byte
// - status read served even busy or locked
// - ready set only with output data
// - busy during execution or penalty, no traffic
// - init complete sticky after challenge reply success
// - error code bits 7:5, bits 4:3 zero
// - error codes 1 and 3 force busy
// - write to status register is nacked
// - address upper six bits must match
// - command path address nacked while busy
module shc_cmd_port
  import shc_pkg::*;
#(
  parameter int EXEC_MAX_CYC  = `SHC_EXEC_MAX_CYC,
  parameter int SEC_DELAY_CYC = `SHC_SEC_DELAY_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] dev_addr,
  output logic            exec_start,
  output logic [7:0]      exec_cmd,
  output logic [7:0]      exec_len,
  input  wire logic       exec_done,
  input  wire shc_err_e   exec_err,
  input  wire logic [7:0] exec_out_size,
  input  wire logic       eng_we,
  input  wire logic [7:0] eng_addr,
  input  wire logic [7:0] eng_wdata,
  input  wire logic [7:0] eng_raddr,
  output logic [7:0]      eng_rdata,
  output shc_stat_s       status_flags
);

  typedef struct packed {
    shc_state_e  state;
    logic        scl_m;
    logic        scl_s;
    logic        scl_p;
    logic        sda_m;
    logic        sda_s;
    logic        sda_p;
    logic [7:0]  shift;
    logic [3:0]  bitc;
    logic        rw;
    logic        stat_path;
    logic        first;
    logic [7:0]  rptr;
    logic [8:0]  wcnt;
    logic [7:0]  ordinal;
    logic [7:0]  opsize;
    logic        oe;
    logic        exec_run;
    logic        penalty;
    logic        locked;
    logic        exec_start;
    logic [31:0] timer;
    logic        outrdy;
    logic        init_done;
    shc_err_e    err;
    logic [7:0]  res_size;
    logic        buf_we;
    logic [7:0]  buf_waddr;
    logic [7:0]  buf_wdata;
    shc_stat_s   stat;
  } shc_st_s;

  shc_st_s    s_ff;
  shc_st_s    nxt_s;
  logic [7:0] rdata_a;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       busy_c;

  // ============================================================
  // ordinal decode
  function automatic logic shc_ord_legal(input logic [7:0] o);
    shc_ord_legal = (o >= `SHC_ORD_FIRMWARE_VERIFY) &&
                    (o <= `SHC_ORD_CLEAR_STATE);
  endfunction : shc_ord_legal

  function automatic logic shc_ord_penalty(input logic [7:0] o);
    shc_ord_penalty = (o >= `SHC_ORD_CRUNCH_OP);
  endfunction : shc_ord_penalty

  // ============================================================
  // shared buffer: host writes operands, engine writes results
  // the last operand lands in the launch cycle, so the host port wins
  shc_buf_mem #(
    .DW (8),
    .AW (8)
  ) u_buf (
    .mclk    (mclk),
    .we      (s_ff.buf_we | (s_ff.exec_run & eng_we)),
    .waddr   (s_ff.buf_we ? s_ff.buf_waddr : eng_addr),
    .wdata   (s_ff.buf_we ? s_ff.buf_wdata : eng_wdata),
    .raddr_a (s_ff.rptr),
    .rdata_a (rdata_a),
    .raddr_b (eng_raddr),
    .rdata_b (eng_rdata)
  );

  // ============================================================
  // next state
  always_comb begin
    logic [7:0] byte_v;
    logic       ack_v;
    logic       launch_v;
    byte_v   = 8'h00;
    ack_v    = 1'b0;
    launch_v = 1'b0;
    nxt_s    = s_ff;
    // only the second stage and its delayed copy are ever looked at
    nxt_s.scl_m = scl_in;
    nxt_s.scl_s = s_ff.scl_m;
    nxt_s.scl_p = s_ff.scl_s;
    nxt_s.sda_m = sda_in;
    nxt_s.sda_s = s_ff.sda_m;
    nxt_s.sda_p = s_ff.sda_s;
    rise    = s_ff.scl_s & ~s_ff.scl_p;
    fall    = ~s_ff.scl_s & s_ff.scl_p;
    start_c = s_ff.scl_s & s_ff.scl_p & s_ff.sda_p & ~s_ff.sda_s;
    stop_c  = s_ff.scl_s & s_ff.scl_p & ~s_ff.sda_p & s_ff.sda_s;
    nxt_s.exec_start = 1'b0;
    nxt_s.buf_we     = 1'b0;

    // execution watchdog and penalty timer share one counter
    if (s_ff.exec_run) begin
      if (exec_done || s_ff.timer == 32'(EXEC_MAX_CYC - 1)) begin
        nxt_s.exec_run = 1'b0;
        nxt_s.err      = exec_done ? exec_err : SHC_ERR_BAD_CMD;
        if (exec_done && exec_err == SHC_ERR_RST_LOCK) begin
          nxt_s.locked = 1'b1;
        end
        if (exec_done && exec_err == SHC_ERR_OK) begin
          nxt_s.res_size = exec_out_size;
          nxt_s.outrdy   = (exec_out_size != 8'h00);
          if (s_ff.ordinal == `SHC_ORD_CHALLENGE_REPLY) begin
            nxt_s.init_done = 1'b1;
          end
        end else begin
          nxt_s.res_size = 8'h00;
          nxt_s.outrdy   = 1'b0;
        end
      end else begin
        nxt_s.timer = s_ff.timer + 32'd1;
      end
    end else if (s_ff.penalty) begin
      if (s_ff.timer == 32'(SEC_DELAY_CYC - 1)) begin
        nxt_s.penalty = 1'b0;
        nxt_s.err     = SHC_ERR_BAD_CMD;
      end else begin
        nxt_s.timer = s_ff.timer + 32'd1;
      end
    end

    // two-wire slave, no clock stretching
    if (start_c) begin
      nxt_s.state = SHC_ADDR;
      nxt_s.bitc  = 4'h0;
      nxt_s.oe    = 1'b0;
    end else if (stop_c) begin
      nxt_s.state = SHC_IDLE;
      nxt_s.oe    = 1'b0;
    end else begin
      case (s_ff.state)
        SHC_ADDR: begin
          if (rise) begin
            nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s};
            nxt_s.bitc  = s_ff.bitc + 4'h1;
          end
          if (fall && s_ff.bitc == 4'h8) begin
            nxt_s.rw        = s_ff.shift[`SHC_ADDR_RW_BIT];
            nxt_s.stat_path = s_ff.shift[`SHC_ADDR_PATH_BIT];
            ack_v = (s_ff.shift[`SHC_ADDR_MATCH_HI:`SHC_ADDR_MATCH_LO] ==
                     dev_addr[`SHC_ADDR_MATCH_HI:`SHC_ADDR_MATCH_LO]);
            if (s_ff.shift[`SHC_ADDR_PATH_BIT]) begin
              ack_v = ack_v & s_ff.shift[`SHC_ADDR_RW_BIT];
            end else begin
              ack_v = ack_v & ~s_ff.stat.busy;
            end
            nxt_s.state = ack_v ? SHC_AACK : SHC_IDLE;
            nxt_s.oe    = ack_v;
            nxt_s.first = 1'b1;
            nxt_s.rptr  = 8'h00;
            nxt_s.wcnt  = 9'h000;
          end
        end
        SHC_AACK, SHC_RACK: begin
          if (s_ff.state == SHC_RACK && rise && s_ff.sda_s) begin
            nxt_s.state = SHC_IDLE;
          end else if (fall && !s_ff.rw) begin
            nxt_s.state = SHC_WRB;
            nxt_s.oe    = 1'b0;
            nxt_s.bitc  = 4'h0;
          end else if (fall) begin
            if (s_ff.stat_path) begin
              byte_v = s_ff.stat;
            end else if (s_ff.first) begin
              byte_v = s_ff.res_size;
            end else begin
              byte_v     = rdata_a;
              nxt_s.rptr = s_ff.rptr + 8'h01;
            end
            nxt_s.first = 1'b0;
            nxt_s.state = SHC_RDB;
            nxt_s.oe    = ~byte_v[7];
            nxt_s.shift = {byte_v[6:0], 1'b0};
            nxt_s.bitc  = 4'h0;
          end
        end
        SHC_RDB: begin
          if (rise) begin
            nxt_s.bitc = s_ff.bitc + 4'h1;
          end
          if (fall && s_ff.bitc == 4'h8) begin
            nxt_s.state = SHC_RACK;
            nxt_s.oe    = 1'b0;
          end else if (fall) begin
            nxt_s.oe    = ~s_ff.shift[7];
            nxt_s.shift = {s_ff.shift[6:0], 1'b0};
          end
        end
        SHC_WRB: begin
          if (rise) begin
            nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s};
            nxt_s.bitc  = s_ff.bitc + 4'h1;
          end
          if (fall && s_ff.bitc == 4'h8) begin
            nxt_s.wcnt = s_ff.wcnt + 9'h001;
            if (s_ff.stat.busy) begin
              ack_v = 1'b0;
            end else if (s_ff.wcnt == 9'h000) begin
              nxt_s.ordinal = s_ff.shift;
              ack_v = shc_ord_legal(s_ff.shift);
              if (shc_ord_penalty(s_ff.shift)) begin
                nxt_s.penalty = 1'b1;
                nxt_s.err     = SHC_ERR_TIMED;
                nxt_s.timer   = 32'd0;
              end else if (!ack_v) begin
                nxt_s.err = SHC_ERR_BAD_CMD;
              end
            end else if (s_ff.wcnt == 9'h001) begin
              nxt_s.opsize = s_ff.shift;
              ack_v        = 1'b1;
              launch_v     = (s_ff.shift == 8'h00);
            end else begin
              // operands overwrite the old response in place
              nxt_s.buf_we    = 1'b1;
              nxt_s.buf_waddr = 8'(s_ff.wcnt - 9'h002);
              nxt_s.buf_wdata = s_ff.shift;
              ack_v           = 1'b1;
              launch_v = (s_ff.wcnt - 9'h001 == {1'b0, s_ff.opsize});
            end
            nxt_s.state = ack_v ? SHC_WACK : SHC_IDLE;
            nxt_s.oe    = ack_v;
          end
        end
        SHC_WACK: begin
          if (fall) begin
            nxt_s.state = SHC_WRB;
            nxt_s.oe    = 1'b0;
            nxt_s.bitc  = 4'h0;
          end
        end
        default: begin
          nxt_s.oe = 1'b0;
        end
      endcase
    end

    if (launch_v) begin
      nxt_s.exec_run   = 1'b1;
      nxt_s.exec_start = 1'b1;
      nxt_s.timer      = 32'd0;
      nxt_s.err        = SHC_ERR_OK;
    end

    busy_c = nxt_s.exec_run | nxt_s.penalty | nxt_s.locked;
    nxt_s.stat.output_ready  = nxt_s.outrdy & ~busy_c;
    nxt_s.stat.busy          = busy_c;
    nxt_s.stat.init_complete = nxt_s.init_done;
    nxt_s.stat.rsvd          = 2'h0;
    nxt_s.stat.err           = nxt_s.err;
  end

  // ============================================================
  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // pin stages start at the idle-high bus level: no false edge
      s_ff       <= '0;
      s_ff.scl_m <= 1'b1;
      s_ff.scl_s <= 1'b1;
      s_ff.scl_p <= 1'b1;
      s_ff.sda_m <= 1'b1;
      s_ff.sda_s <= 1'b1;
      s_ff.sda_p <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sda_out      = 1'b0 & s_ff.oe;
  assign sda_oe       = s_ff.oe;
  assign exec_start   = s_ff.exec_start;
  assign exec_cmd     = s_ff.ordinal;
  assign exec_len     = s_ff.opsize;
  assign status_flags = s_ff.stat;

  // ============================================================
  // checks
  sequence s_addr_done;
    s_ff.state == SHC_ADDR && fall && s_ff.bitc == 4'h8;
  endsequence

  sequence s_addr_ack;
    s_addr_done ##1 s_ff.state == SHC_AACK;
  endsequence

  property p_busy_cmd_nack;
    @(posedge mclk) disable iff (!rst_n)
    s_addr_done and (!s_ff.shift[1] && s_ff.stat.busy) |=> !s_ff.oe;
  endproperty
  a_busy_cmd_nack: assert property (p_busy_cmd_nack)
    else $error("command address acked while busy");

  property p_stat_write_nack;
    @(posedge mclk) disable iff (!rst_n)
    s_addr_done and (s_ff.shift[1:0] == 2'b10) |=> s_ff.state == SHC_IDLE;
  endproperty
  a_stat_write_nack: assert property (p_stat_write_nack)
    else $error("status write was acked");

  property p_addr_mismatch;
    @(posedge mclk) disable iff (!rst_n)
    s_addr_done and (s_ff.shift[7:2] != dev_addr[7:2]) |=> !s_ff.oe;
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch)
    else $error("foreign address acked");

  property p_read_restart;
    @(posedge mclk) disable iff (!rst_n)
    s_addr_ack |-> s_ff.first && s_ff.rptr == 8'h00;
  endproperty
  a_read_restart: assert property (p_read_restart)
    else $error("read did not restart at size byte");

  property p_illegal_penalty;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.state == SHC_WRB && fall && s_ff.bitc == 4'h8 &&
    s_ff.wcnt == 9'h000 && !s_ff.stat.busy && s_ff.shift >= 8'h15
    |=> s_ff.penalty && !s_ff.oe ##1 s_ff.stat.busy;
  endproperty
  a_illegal_penalty: assert property (p_illegal_penalty)
    else $error("illegal ordinal did not start penalty");

  property p_penalty_flags;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.penalty |-> s_ff.stat.busy && s_ff.stat.err == SHC_ERR_TIMED;
  endproperty
  a_penalty_flags: assert property (p_penalty_flags)
    else $error("penalty not shown in status");

  property p_exec_limit;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.exec_run |-> s_ff.timer < 32'(EXEC_MAX_CYC);
  endproperty
  a_exec_limit: assert property (p_exec_limit)
    else $error("execution ran past its limit");

  property p_no_output;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.exec_run && exec_done && exec_out_size == 8'h00
    |=> !s_ff.outrdy && s_ff.res_size == 8'h00 ##1 !s_ff.stat.output_ready;
  endproperty
  a_no_output: assert property (p_no_output)
    else $error("no-output command left ready set");

  property p_ready_hold;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.outrdy && !s_ff.exec_run |=> s_ff.outrdy || s_ff.exec_run;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("output ready dropped without a command");

  property p_init_sticky;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.stat.init_complete |=> s_ff.stat.init_complete;
  endproperty
  a_init_sticky: assert property (p_init_sticky)
    else $error("init complete cleared");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!rst_n)
    s_ff.exec_start |-> s_ff.stat.rsvd == 2'h0 && s_ff.stat.busy;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bits set or not busy");

endmodule : shc_cmd_port

// [shc_host_model.sv]
`timescale 1ns/1ns

// ============================================================
// two-wire bus master; both lines are open drain with pull-ups
module shc_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_rel,
  output logic      sda_pull
);
  // bit time is 12 mclk, the nearest the 10 ns grid gets to 125 ns
  localparam int Q = 3;

  initial begin
    scl_rel  = 1'b1;
    sda_pull = 1'b0;
  end

  // data only moves while scl is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= ~b;
    repeat (Q) @(posedge mclk);
    scl_rel <= 1'b1;
    repeat (Q) @(posedge mclk);
    s = sda_line;
    repeat (Q) @(posedge mclk);
    scl_rel <= 1'b0;
    repeat (Q) @(posedge mclk);
  endtask : bit_io

  task automatic bus_start();
    sda_pull <= 1'b0;
    repeat (Q) @(posedge mclk);
    scl_rel <= 1'b1;
    repeat (Q) @(posedge mclk);
    sda_pull <= 1'b1;
    repeat (Q) @(posedge mclk);
    scl_rel <= 1'b0;
    repeat (Q) @(posedge mclk);
  endtask : bus_start

  task automatic bus_stop();
    sda_pull <= 1'b1;
    repeat (Q) @(posedge mclk);
    scl_rel <= 1'b1;
    repeat (Q) @(posedge mclk);
    sda_pull <= 1'b0;
    repeat (Q) @(posedge mclk);
  endtask : bus_stop

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // stops at the first refused byte, since the device then idles
  task automatic send_cmd(input logic [7:0] adr, input logic [7:0] ord,
                          input logic [7:0] len, output int n);
    logic       a;
    logic [7:0] b;
    n = 0;
    bus_start();
    for (int i = 0; i < int'(len) + 3 && i == n; i++) begin
      b = 8'(8'h4D + i);
      if (i == 0) b = adr;
      if (i == 1) b = ord;
      if (i == 2) b = len;
      wr_byte(b, a);
      if (a) n++;
    end
    bus_stop();
  endtask : send_cmd

  task automatic read_bytes(input logic [7:0] adr, input int cnt,
                            output logic a, output logic [7:0] d [8]);
    logic s;
    bus_start();
    wr_byte(adr, a);
    for (int k = 0; k < cnt && a; k++) begin
      for (int i = 7; i >= 0; i--)
        bit_io(1'b1, d[k][i]);
      bit_io(k == cnt - 1, s);
    end
    bus_stop();
  endtask : read_bytes
endmodule : shc_host_model

// [tb_secure_host_command_port.sv]
`timescale 1ns/1ns
`include "shc_map.svh"

// ============================================================
// engine stub, row table, then refusals, busy, timeout, penalty
module tb_secure_host_command_port
  import shc_pkg::*;
;
  localparam int         T_EXEC = 600;
  localparam logic [7:0] DEV    = 8'hC0;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl_rel, sda_pull, sda_out, sda_oe, sda_line, exec_start;
  logic       exec_done = 1'b0;
  logic       eng_we = 1'b0;
  logic [7:0] eng_addr = 8'h00;
  logic [7:0] eng_wdata = 8'h00;
  logic [7:0] exec_out_size = 8'h00;
  logic [7:0] exec_cmd, exec_len, eng_rdata;
  shc_err_e   exec_err = SHC_ERR_OK;
  shc_stat_s  status_flags;
  logic [7:0] eng_out = 8'h00;
  shc_err_e   eng_err = SHC_ERR_OK;
  int         eng_fill = 0;
  int         eng_delay = 5;
  int         n_mismatch = 0;
  int         check_count = 0;
  logic       init = 1'b0;
  // {ordinal, operand count, out size, engine fill, engine error}
  logic [39:0] rows [20] = '{
    40'h01_00_00_00_00, 40'h02_01_01_00_00, 40'h03_02_00_00_00,
    40'h04_03_02_02_04, 40'h05_00_03_03_00, 40'h06_02_02_00_00,
    40'h07_01_00_00_00, 40'h08_04_04_04_00, 40'h09_03_01_01_00,
    40'h0A_00_04_04_00, 40'h0B_00_00_00_00, 40'h0C_00_02_02_00,
    40'h0D_04_00_00_00, 40'h0E_02_01_00_00, 40'h0F_01_00_00_02,
    40'h10_00_03_03_00, 40'h11_03_02_02_00, 40'h12_00_04_04_00,
    40'h14_01_00_00_00, 40'h13_00_02_02_00
  };

  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_out);
  always #5 mclk = ~mclk;

  shc_cmd_port #(
    .EXEC_MAX_CYC (T_EXEC),
    .SEC_DELAY_CYC(50)
  ) shc_cmd_port_inst (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .scl_in       (scl_rel),
    .sda_in       (sda_line),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .dev_addr     (DEV),
    .exec_start   (exec_start),
    .exec_cmd     (exec_cmd),
    .exec_len     (exec_len),
    .exec_done    (exec_done),
    .exec_err     (exec_err),
    .exec_out_size(exec_out_size),
    .eng_we       (eng_we),
    .eng_addr     (eng_addr),
    .eng_wdata    (eng_wdata),
    .eng_raddr    (8'h00),
    .eng_rdata    (eng_rdata),
    .status_flags (status_flags)
  );

  shc_host_model shc_host_model_inst (
    .mclk    (mclk),
    .sda_line(sda_line),
    .scl_rel (scl_rel),
    .sda_pull(sda_pull)
  );

  // engine stub: fills the buffer, then reports after eng_delay
  initial begin : engine
    forever begin
      @(posedge mclk);
      if (exec_start === 1'b1) begin
        for (int k = 0; k < eng_fill; k++) begin
          eng_we    <= 1'b1;
          eng_addr  <= 8'(k);
          eng_wdata <= 8'(8'hA0 + k);
          @(posedge mclk);
        end
        eng_we <= 1'b0;
        repeat (eng_delay) @(posedge mclk);
        exec_done     <= 1'b1;
        exec_err      <= eng_err;
        exec_out_size <= eng_out;
        @(posedge mclk);
        exec_done <= 1'b0;
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_idle(output int w);
    for (w = 0; w < 2000 && status_flags.busy !== 1'b0; w++)
      @(posedge mclk);
    if (w == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_idle

  task automatic rd_resp(input logic [7:0] out, input logic [7:0] fill);
    logic       a;
    logic [7:0] d [8];
    shc_host_model_inst.read_bytes(DEV | 8'h01, int'(out) + 1, a, d);
    check({7'h00, a}, 8'h01);
    check(d[0], out);
    for (int k = 0; k < out; k++)
      check(d[k + 1], 8'(k < fill ? 8'hA0 + k : 8'h50 + k));
  endtask : rd_resp

  initial begin : main
    logic [7:0] ord, len, out, fill, err;
    logic       a;
    logic [7:0] d [8];
    int         n, w;
    repeat (10) @(posedge mclk);
    check(status_flags, `SHC_STATUS_RESET);
    check({7'h00, sda_oe}, 8'h00);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int r = 0; r < 20; r++) begin
      {ord, len, out, fill, err} = rows[r];
      eng_out  <= out;
      eng_fill <= int'(fill);
      eng_err  <= shc_err_e'(err[2:0]);
      shc_host_model_inst.send_cmd(DEV, ord, len, n);
      check(8'(n), 8'(len + 3));
      check(exec_cmd, ord);
      check(exec_len, len);
      wait_idle(w);
      init = init | (ord == 8'h03 && err == 8'h00);
      check(status_flags, {err[2:0], 2'b00, init, 1'b0,
                           out != 8'h00 && err == 8'h00});
      if (fill != 0 || len != 0)
        check(eng_rdata, fill != 0 ? 8'hA0 : 8'h50);
      if (err == 8'h00)
        rd_resp(out, fill);
    end
    rd_resp(out, fill);
    eng_out  <= 8'h00;
    eng_fill <= 0;
    fork
      shc_host_model_inst.send_cmd(DEV, 8'h14, 8'h04, n);
      begin
        repeat (500) @(posedge mclk);
        check({7'h00, status_flags.output_ready}, 8'h01);
      end
    join
    wait_idle(w);
    check(status_flags, {5'h00, init, 2'b00});
    rd_resp(8'h00, 8'h00);
    shc_host_model_inst.send_cmd(DEV | 8'h02, 8'h01, 8'h00, n);
    check(8'(n), 8'h00);
    shc_host_model_inst.send_cmd(DEV ^ 8'h04, 8'h01, 8'h00, n);
    check(8'(n), 8'h00);
    eng_delay <= 500;
    shc_host_model_inst.send_cmd(DEV, 8'h01, 8'h00, n);
    shc_host_model_inst.read_bytes(DEV | 8'h03, 1, a, d);
    check(d[0], {5'h00, init, 2'b10});
    shc_host_model_inst.send_cmd(DEV, 8'h01, 8'h00, n);
    check(8'(n), 8'h00);
    wait_idle(w);
    // engine answers too late, so the port must give up on its own
    eng_delay <= 700;
    shc_host_model_inst.send_cmd(DEV, 8'h01, 8'h00, n);
    wait_idle(w);
    check(8'(w > 500), 8'h01);
    check(status_flags, {SHC_ERR_BAD_CMD, 2'b00, init, 2'b00});
    for (int i = 0; i < 3; i++) begin
      ord = i == 0 ? 8'h15 : i == 1 ? 8'hFF : 8'h00;
      shc_host_model_inst.send_cmd(DEV, ord, 8'h00, n);
      check(8'(n), 8'h01);
      check({7'h00, status_flags.busy}, {7'h00, ord != 8'h00});
      wait_idle(w);
      check(status_flags, {SHC_ERR_BAD_CMD, 2'b00, init, 2'b00});
    end
    eng_delay <= 5;
    eng_err   <= SHC_ERR_RST_LOCK;
    shc_host_model_inst.send_cmd(DEV, 8'h01, 8'h00, n);
    repeat (20) @(posedge mclk);
    check(status_flags, {SHC_ERR_RST_LOCK, 2'b00, init, 2'b10});
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check(status_flags, `SHC_STATUS_RESET);
    report_and_stop();
  end
endmodule : tb_secure_host_command_port
